// ===== irq2_pin_pkg.sv
package irq2_pin_pkg;

  // register offsets
  localparam logic [6:0] ADDR_OVF_FLAGS = 7'h2A;
  localparam logic [6:0] ADDR_ADC_FLAGS = 7'h2D;
  localparam logic [6:0] ADDR_IRQ2_CTRL = 7'h31;
  localparam logic [6:0] ADDR_RSVD_GAP = 7'h32;
  localparam logic [6:0] ADDR_PIN_CTRL = 7'h33;

  // second interrupt source control fields
  localparam int CTRL_AGC_BIT = 4;
  localparam int CTRL_ENG_BIT = 2;
  localparam int CTRL_DAV_BIT = 1;
  localparam int CTRL_REP_BIT = 0;
  localparam logic [7:0] CTRL_WR_MASK = 8'h17;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // mic clock pin control fields
  localparam int PIN_FUNC_LSB = 2;
  localparam int PIN_FUNC_MSB = 5;
  localparam int PIN_IN_BIT = 1;
  localparam int PIN_GPO_BIT = 0;
  localparam logic [7:0] PIN_WR_MASK = 8'h3D;
  localparam logic [7:0] PIN_RST = 8'h00;

  // sticky flag fields
  localparam int OVF_LSB = 1;
  localparam int ADC_LSB = 3;
  localparam logic [2:0] OVF_RST = 3'h0;
  localparam logic [3:0] ADC_RST = 4'h0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // pin function codes
  typedef enum logic [3:0] {
    FN_OFF = 4'h0,
    FN_INPUT = 4'h1,
    FN_GEN_IN = 4'h2,
    FN_GPO = 4'h3,
    FN_DIV_CLK = 4'h4,
    FN_IRQ1 = 4'h5,
    FN_IRQ2 = 4'h6,
    FN_SEC_BCLK = 4'h8,
    FN_SEC_WCLK = 4'h9,
    FN_MOD_CLK = 4'hA
  } pin_func_e;

  // pulse timing
  localparam int CLK_MHZ = 250;
  localparam int PULSE_US = 2000;
  localparam int PERIOD_US = 4000;
  localparam int PULSE_CYCLES = PULSE_US * CLK_MHZ;
  localparam int GAP_CYCLES = (PERIOD_US - PULSE_US) * CLK_MHZ;
  localparam int CNT_W = 24;

  // pulse generator states, gray along idle-high-low
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_HIGH = 2'b01,
    PS_LOW = 2'b11
  } pulse_state_e;

endpackage

// ===== irq2_pulse_if.sv
`timescale 1ns/1ps
interface irq2_pulse_if;
  logic trigger;
  logic repeat_en;
  logic stop;
  logic irq;
  modport ctl (output trigger, output repeat_en, output stop, input irq);
  modport gen (input trigger, input repeat_en, input stop, output irq);
endinterface // irq2_pulse_if

// ===== irq2_pulse_gen.sv
`timescale 1ns/1ps
module irq2_pulse_gen #(
  parameter int HIGH_CYCLES = irq2_pin_pkg::PULSE_CYCLES,
  parameter int LOW_CYCLES = irq2_pin_pkg::GAP_CYCLES
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // control side
  irq2_pulse_if.gen pulse
);

  localparam logic [irq2_pin_pkg::CNT_W-1:0] HIGH_LAST =
    irq2_pin_pkg::CNT_W'(HIGH_CYCLES - 1);
  localparam logic [irq2_pin_pkg::CNT_W-1:0] LOW_LAST =
    irq2_pin_pkg::CNT_W'(LOW_CYCLES - 1);

  irq2_pin_pkg::pulse_state_e state_q, state_d;
  logic [irq2_pin_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic stop_seen_q, stop_seen_d;

  // next state of the pulse train
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    stop_seen_d = stop_seen_q | pulse.stop;
    case (state_q)
      irq2_pin_pkg::PS_IDLE:
      begin
        stop_seen_d = 1'b0;
        if (pulse.trigger)
        begin
          state_d = irq2_pin_pkg::PS_HIGH;
          cnt_d = HIGH_LAST;
        end
      end
      irq2_pin_pkg::PS_HIGH:
      begin
        if (cnt_q != '0)
          cnt_d = cnt_q - 1'b1;
        else if (pulse.repeat_en && !stop_seen_q && !pulse.stop)
        begin
          state_d = irq2_pin_pkg::PS_LOW;
          cnt_d = LOW_LAST;
        end
        else
          state_d = irq2_pin_pkg::PS_IDLE;
      end
      irq2_pin_pkg::PS_LOW:
      begin
        if (pulse.stop || stop_seen_q || !pulse.repeat_en)
          state_d = irq2_pin_pkg::PS_IDLE;
        else if (cnt_q != '0)
          cnt_d = cnt_q - 1'b1;
        else
        begin
          state_d = irq2_pin_pkg::PS_HIGH;
          cnt_d = HIGH_LAST;
        end
      end
      default:
        state_d = irq2_pin_pkg::PS_IDLE;
    endcase
  end

  // register pulse state
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_q <= irq2_pin_pkg::PS_IDLE;
      cnt_q <= '0;
      stop_seen_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      stop_seen_q <= stop_seen_d;
    end
  end

  // active-high interrupt straight from state flops
  assign pulse.irq = (state_q == irq2_pin_pkg::PS_HIGH);

endmodule // irq2_pulse_gen

// ===== irq2_pin_ctrl.sv
`timescale 1ns/1ps
// Function
// - control D4 gates noise source
// - control D2 gates engine and overflow sources
// - control D1 gates data-available source
// - D0 clear gives one 2 ms pulse
// - D0 set repeats until flag read
// - code 0000 powers pin down
// - code 0001 pin is input
// - code 0010 general input
// - D1 shows input buffer, read-only
// - code 0011 drives D0 value
// - code 0100 drives divided clock
// - codes 0101/0110 drive interrupts
// - codes 1000/1001 drive secondary clocks
// - code 1010 drives modulator clock
// - flags sticky, cleared by read
module irq2_pin_ctrl #(
  parameter int PULSE_CYCLES = irq2_pin_pkg::PULSE_CYCLES,
  parameter int GAP_CYCLES = irq2_pin_pkg::GAP_CYCLES
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // register port
  input wire logic [6:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // interrupt event sources, one-cycle pulses
  input wire logic [1:0] i_agc_noise_evt,
  input wire logic [1:0] i_engine_irq_evt,
  input wire logic [2:0] i_overflow_evt,
  input wire logic i_data_avail_evt,
  // signals offered to the pin
  input wire logic i_first_interrupt_output,
  input wire logic i_divided_clock_output,
  input wire logic i_sec_bit_clk,
  input wire logic i_sec_word_clk,
  input wire logic i_converter_modulator_clock,
  // mic clock multifunction pin
  input wire logic i_mic_pin,
  output logic o_mic_pin,
  output logic o_mic_pin_oe,
  output logic o_mic_pin_in_en,
  output logic o_mic_pin_as_input,
  // second interrupt output
  output logic o_second_interrupt_output
);

  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] pin_q, pin_d;
  logic [2:0] ovf_q, ovf_d;
  logic [3:0] adc_q, adc_d;
  logic [7:0] rdata_q, rdata_d;
  logic pin_in_q, pin_in_d;
  logic pin_out_q, pin_out_d;
  logic pin_oe_q, pin_oe_d;
  logic rd_ovf, rd_adc;
  logic [3:0] adc_evt;
  logic [3:0] func;

  irq2_pulse_if pulse ();

  assign func = pin_q[irq2_pin_pkg::PIN_FUNC_MSB:irq2_pin_pkg::PIN_FUNC_LSB];
  assign rd_ovf = i_reg_rd && (i_reg_addr == irq2_pin_pkg::ADDR_OVF_FLAGS);
  assign rd_adc = i_reg_rd && (i_reg_addr == irq2_pin_pkg::ADDR_ADC_FLAGS);
  assign adc_evt = {i_agc_noise_evt, i_engine_irq_evt};

  // control registers, only writable bits stored
  always_comb
  begin
    ctrl_d = ctrl_q;
    pin_d = pin_q;
    if (i_reg_wr && i_reg_addr == irq2_pin_pkg::ADDR_IRQ2_CTRL)
      ctrl_d = i_reg_wdata & irq2_pin_pkg::CTRL_WR_MASK;
    if (i_reg_wr && i_reg_addr == irq2_pin_pkg::ADDR_PIN_CTRL)
      pin_d = i_reg_wdata & irq2_pin_pkg::PIN_WR_MASK;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ctrl_q <= irq2_pin_pkg::CTRL_RST;
      pin_q <= irq2_pin_pkg::PIN_RST;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      pin_q <= pin_d;
    end
  end

  // sticky flags, a new event wins over the read clear
  always_comb
  begin
    ovf_d = (rd_ovf ? irq2_pin_pkg::OVF_RST : ovf_q) | i_overflow_evt;
    adc_d = (rd_adc ? irq2_pin_pkg::ADC_RST : adc_q) | adc_evt;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ovf_q <= irq2_pin_pkg::OVF_RST;
      adc_q <= irq2_pin_pkg::ADC_RST;
    end
    else
    begin
      ovf_q <= ovf_d;
      adc_q <= adc_d;
    end
  end

  // read mux, registered one cycle after the strobe
  always_comb
  begin
    rdata_d = rdata_q;
    if (i_reg_rd)
    begin
      rdata_d = irq2_pin_pkg::RDATA_RST;
      case (i_reg_addr)
        irq2_pin_pkg::ADDR_OVF_FLAGS:
          rdata_d[irq2_pin_pkg::OVF_LSB +: 3] = ovf_q;
        irq2_pin_pkg::ADDR_ADC_FLAGS:
          rdata_d[irq2_pin_pkg::ADC_LSB +: 4] = adc_q;
        irq2_pin_pkg::ADDR_IRQ2_CTRL:
          rdata_d = ctrl_q;
        irq2_pin_pkg::ADDR_RSVD_GAP:
          rdata_d = irq2_pin_pkg::RDATA_RST;
        irq2_pin_pkg::ADDR_PIN_CTRL:
        begin
          rdata_d = pin_q;
          rdata_d[irq2_pin_pkg::PIN_IN_BIT] = pin_in_q;
        end
        default:
          rdata_d = irq2_pin_pkg::RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      rdata_q <= irq2_pin_pkg::RDATA_RST;
    else
      rdata_q <= rdata_d;
  end

  assign o_reg_rdata = rdata_q;

  // enabled sources or-ed into a start request
  assign pulse.trigger =
    (ctrl_q[irq2_pin_pkg::CTRL_AGC_BIT] && (|i_agc_noise_evt)) ||
    (ctrl_q[irq2_pin_pkg::CTRL_ENG_BIT] &&
     ((|i_engine_irq_evt) || (|i_overflow_evt))) ||
    (ctrl_q[irq2_pin_pkg::CTRL_DAV_BIT] && i_data_avail_evt);
  assign pulse.repeat_en = ctrl_q[irq2_pin_pkg::CTRL_REP_BIT];
  assign pulse.stop = rd_ovf || rd_adc;

  irq2_pulse_gen #(
    .HIGH_CYCLES(PULSE_CYCLES),
    .LOW_CYCLES(GAP_CYCLES)
  ) u_pulse (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .pulse(pulse)
  );

  assign o_second_interrupt_output = pulse.irq;

  // pin function mux
  always_comb
  begin
    pin_in_d = 1'b0;
    pin_out_d = 1'b0;
    pin_oe_d = 1'b1;
    case (func)
      irq2_pin_pkg::FN_OFF:
        pin_oe_d = 1'b0;
      irq2_pin_pkg::FN_INPUT,
      irq2_pin_pkg::FN_GEN_IN:
      begin
        pin_oe_d = 1'b0;
        pin_in_d = i_mic_pin;
      end
      irq2_pin_pkg::FN_GPO:
        pin_out_d = pin_q[irq2_pin_pkg::PIN_GPO_BIT];
      irq2_pin_pkg::FN_DIV_CLK:
        pin_out_d = i_divided_clock_output;
      irq2_pin_pkg::FN_IRQ1:
        pin_out_d = i_first_interrupt_output;
      irq2_pin_pkg::FN_IRQ2:
        pin_out_d = pulse.irq;
      irq2_pin_pkg::FN_SEC_BCLK:
        pin_out_d = i_sec_bit_clk;
      irq2_pin_pkg::FN_SEC_WCLK:
        pin_out_d = i_sec_word_clk;
      irq2_pin_pkg::FN_MOD_CLK:
        pin_out_d = i_converter_modulator_clock;
      default:
        pin_oe_d = 1'b0; // reserved codes leave pin undriven
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      pin_in_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end
    else
    begin
      pin_in_q <= pin_in_d;
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  // pin outputs
  assign o_mic_pin = pin_out_q;
  assign o_mic_pin_oe = pin_oe_q;
  assign o_mic_pin_in_en = (func == irq2_pin_pkg::FN_INPUT) ||
                           (func == irq2_pin_pkg::FN_GEN_IN);
  assign o_mic_pin_as_input = (func == irq2_pin_pkg::FN_INPUT);

endmodule // irq2_pin_ctrl

// ===== irq2_pin_ctrl_sva.sv
`timescale 1ns/1ps
module irq2_pin_ctrl_sva #(
  parameter int PULSE_CYCLES = 8,
  parameter int GAP_CYCLES = 8
) (
  // clock, reset, register port
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [6:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // event and outputs
  input wire logic i_data_avail_evt,
  input wire logic o_mic_pin,
  input wire logic o_mic_pin_oe,
  input wire logic o_mic_pin_in_en,
  input wire logic o_mic_pin_as_input,
  input wire logic o_second_interrupt_output
);
  logic [7:0] ctrl_q;
  logic [7:0] pin_q;
  logic [5:0] hi_q;
  logic [5:0] lo_q;
  // shadow registers and run-length counters of the interrupt
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ctrl_q <= 8'h00;
      pin_q <= 8'h00;
      hi_q <= 6'h00;
      lo_q <= 6'h00;
    end
    else
    begin
      if (i_reg_wr && i_reg_addr == irq2_pin_pkg::ADDR_IRQ2_CTRL)
        ctrl_q <= i_reg_wdata & irq2_pin_pkg::CTRL_WR_MASK;
      if (i_reg_wr && i_reg_addr == irq2_pin_pkg::ADDR_PIN_CTRL)
        pin_q <= i_reg_wdata & irq2_pin_pkg::PIN_WR_MASK;
      hi_q <= o_second_interrupt_output ? hi_q + 6'h01 : 6'h00;
      lo_q <= o_second_interrupt_output ? 6'h00 : (lo_q == 6'h3F ? lo_q : lo_q + 6'h01);
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // enabled event seen while long idle
  sequence idle_evt;
    ctrl_q[1] && i_data_avail_evt && lo_q > GAP_CYCLES;
  endsequence
  trig_start_a:
    assert property (idle_evt |=> o_second_interrupt_output) else $error("no pulse after event");
  pulse_len_a:
    assert property ($fell(o_second_interrupt_output) |-> hi_q == PULSE_CYCLES)
    else $error("pulse width wrong");
  src_mask_a:
    assert property (!o_second_interrupt_output && ctrl_q[4:0] == 5'h00
      |=> !o_second_interrupt_output) else $error("pulse with all sources off");
  gap_read_a:
    assert property (i_reg_rd && i_reg_addr == irq2_pin_pkg::ADDR_RSVD_GAP
      |=> o_reg_rdata == 8'h00) else $error("gap register not zero");
  ctrl_read_a:
    assert property (i_reg_rd && i_reg_addr == irq2_pin_pkg::ADDR_IRQ2_CTRL
      |=> o_reg_rdata == $past(ctrl_q)) else $error("control readback wrong");
  in_buf_a:
    assert property (o_mic_pin_in_en == (pin_q[5:2] == 4'h1 || pin_q[5:2] == 4'h2))
    else $error("input buffer enable wrong");
  as_input_a:
    assert property (o_mic_pin_as_input == (pin_q[5:2] == 4'h1)) else $error("input mode wrong");
  pin_off_a:
    assert property (pin_q[5:2] == 4'h0 |=> !o_mic_pin_oe) else $error("pin driven while off");
  gpo_level_a:
    assert property (pin_q[5:2] == 4'h3 |=> o_mic_pin_oe && o_mic_pin == $past(pin_q[0]))
    else $error("output level wrong");
endmodule // irq2_pin_ctrl_sva

bind irq2_pin_ctrl irq2_pin_ctrl_sva #(.PULSE_CYCLES(PULSE_CYCLES), .GAP_CYCLES(GAP_CYCLES)) u_sva (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .i_data_avail_evt(i_data_avail_evt), .o_mic_pin(o_mic_pin), .o_mic_pin_oe(o_mic_pin_oe),
  .o_mic_pin_in_en(o_mic_pin_in_en), .o_mic_pin_as_input(o_mic_pin_as_input),
  .o_second_interrupt_output(o_second_interrupt_output));

// ===== irq2_host_model.sv
`timescale 1ns/1ps
module irq2_host_model (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // from the device
  input wire logic i_irq,
  input wire logic i_pin_oe,
  input wire logic i_pin_drv,
  input wire logic i_ext_level,
  // resolved pin and pulse tally
  output logic o_pin_level,
  output logic [7:0] o_irq_count
);
  logic irq_q;
  // device wins while it drives, else the outside source sets the wire
  assign o_pin_level = i_pin_oe ? i_pin_drv : i_ext_level;
  // count rising edges of the interrupt line
  always_ff @(posedge i_core_clk)
  begin
    irq_q <= i_rst ? 1'b0 : i_irq;
    if (i_rst)
      o_irq_count <= 8'h00;
    else if (i_irq && !irq_q)
      o_irq_count <= o_irq_count + 8'h01;
  end
endmodule // irq2_host_model

// ===== irq2_pin_ctrl_tb.sv
`timescale 1ns/1ps
module irq2_pin_ctrl_tb;
  logic clk, rst, wr, rd, dav, ext, oe, ien, asin, pin_o, irq, lvl;
  logic [1:0] agc, eng;
  logic [2:0] ovf;
  logic [4:0] srcs;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, v, cnt, n0;
  logic [8:0] r;
  int num_errors, check_count;
  // rows: func, d0, selected source level, oe, input enable, pin; legal codes only
  logic [8:0] rows [11] = '{9'h018, 9'h02A, 9'h04A, 9'h07D, 9'h064, 9'h08D, 9'h0AD,
    9'h0C4, 9'h104, 9'h12D, 9'h14D};
  localparam logic [7:0] ENS [4] = '{8'h10, 8'h04, 8'h04, 8'h02};
  localparam logic [7:0] EVS [4] = '{8'hC0, 8'h30, 8'h0E, 8'h01};
  // one-hot source per pin code; unselected sources carry the inverse level
  localparam logic [4:0] SEL [16] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h02, 5'h01, 5'h00, 5'h00,
    5'h04, 5'h08, 5'h10, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
  // device under test with short pulse counts
  irq2_pin_ctrl #(.PULSE_CYCLES(8), .GAP_CYCLES(8)) dut (
    .i_core_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .i_agc_noise_evt(agc), .i_engine_irq_evt(eng),
    .i_overflow_evt(ovf), .i_data_avail_evt(dav), .i_first_interrupt_output(srcs[0]),
    .i_divided_clock_output(srcs[1]), .i_sec_bit_clk(srcs[2]), .i_sec_word_clk(srcs[3]),
    .i_converter_modulator_clock(srcs[4]), .i_mic_pin(lvl), .o_mic_pin(pin_o),
    .o_mic_pin_oe(oe), .o_mic_pin_in_en(ien), .o_mic_pin_as_input(asin),
    .o_second_interrupt_output(irq));
  // far side of pin and interrupt
  irq2_host_model host (.i_core_clk(clk), .i_rst(rst), .i_irq(irq), .i_pin_oe(oe),
    .i_pin_drv(pin_o), .i_ext_level(ext), .o_pin_level(lvl), .o_irq_count(cnt));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // register write; gap register is never written
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // register read, data one cycle after the strobe
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
  // one-cycle event pulse, packed agc, engine, overflow, data-available
  task automatic fire(input logic [7:0] e);
    @(negedge clk);
    {agc, eng, ovf, dav} = e;
    @(negedge clk);
    {agc, eng, ovf, dav} = 8'h00;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // watchdog
  initial
  begin
    #20000;
    num_errors++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    {rst, wr, rd, srcs, addr, wdata, agc, eng, ovf, dav} = '0;
    rst = 1'b1;
    ext = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd_reg(irq2_pin_pkg::ADDR_IRQ2_CTRL, v);
    chk(v, irq2_pin_pkg::CTRL_RST);
    rd_reg(irq2_pin_pkg::ADDR_PIN_CTRL, v);
    chk(v, irq2_pin_pkg::PIN_RST);
    rd_reg(irq2_pin_pkg::ADDR_RSVD_GAP, v);
    chk(v, 8'h00);
    foreach (rows[i])
    begin
      r = rows[i];
      srcs = r[3] ? SEL[r[8:5]] : ~SEL[r[8:5]];
      wr_reg(irq2_pin_pkg::ADDR_PIN_CTRL, {2'b00, r[8:5], 1'b1, r[4]});
      repeat (3) @(negedge clk);
      chk({5'h00, oe, ien, asin}, {5'h00, r[2], r[1], r[8:5] == 4'h1});
      if (r[2])
        chk({7'h00, pin_o}, {7'h00, r[0]});
      rd_reg(irq2_pin_pkg::ADDR_PIN_CTRL, v);
      chk(v, {2'b00, r[8:5], r[1], r[4]});
    end
    // input buffer tracks a low level
    wr_reg(irq2_pin_pkg::ADDR_PIN_CTRL, 8'h08);
    ext = 1'b0;
    repeat (3) @(negedge clk);
    rd_reg(irq2_pin_pkg::ADDR_PIN_CTRL, v);
    chk(v, 8'h08);
    ext = 1'b1;
    // each source masked, then enabled, in single-pulse mode
    for (int i = 0; i < 4; i++)
    begin
      n0 = cnt;
      wr_reg(irq2_pin_pkg::ADDR_IRQ2_CTRL, ~ENS[i] & 8'h16);
      fire(EVS[i]);
      repeat (20) @(negedge clk);
      chk(cnt, n0);
      wr_reg(irq2_pin_pkg::ADDR_IRQ2_CTRL, ENS[i]);
      fire(EVS[i]);
      repeat (20) @(negedge clk);
      chk(cnt, n0 + 8'h01);
    end
    // sticky flags clear on read
    wr_reg(irq2_pin_pkg::ADDR_IRQ2_CTRL, 8'h00);
    rd_reg(irq2_pin_pkg::ADDR_ADC_FLAGS, v);
    rd_reg(irq2_pin_pkg::ADDR_OVF_FLAGS, v);
    fire(8'hFE);
    rd_reg(irq2_pin_pkg::ADDR_ADC_FLAGS, v);
    chk(v, 8'h78);
    rd_reg(irq2_pin_pkg::ADDR_OVF_FLAGS, v);
    chk(v, 8'h0E);
    rd_reg(irq2_pin_pkg::ADDR_ADC_FLAGS, v);
    chk(v, 8'h00);
    // pulse train stopped by either flag read
    wr_reg(irq2_pin_pkg::ADDR_IRQ2_CTRL, 8'h03);
    for (int k = 0; k < 2; k++)
    begin
      n0 = cnt;
      fire(8'h01);
      repeat (40) @(negedge clk);
      chk(cnt, n0 + 8'h03);
      rd_reg(k ? irq2_pin_pkg::ADDR_OVF_FLAGS : irq2_pin_pkg::ADDR_ADC_FLAGS, v);
      repeat (20) @(negedge clk);
      n0 = cnt;
      repeat (40) @(negedge clk);
      chk(cnt, n0);
    end
    // stop read during a high phase lets that pulse finish, then ends the train
    n0 = cnt;
    fire(8'h01);
    repeat (3) @(negedge clk);
    rd_reg(irq2_pin_pkg::ADDR_ADC_FLAGS, v);
    repeat (40) @(negedge clk);
    chk(cnt, n0 + 8'h01);
    // second reset in mid-run
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd_reg(irq2_pin_pkg::ADDR_IRQ2_CTRL, v);
    chk(v, irq2_pin_pkg::CTRL_RST);
    wrap_up();
  end
endmodule // irq2_pin_ctrl_tb
